// [hw/wake_timer_dev.sv]
// device end: fixed-interval wake-up timer started by the host
`timescale 1ns/1ps
module wake_timer_dev #(
  parameter logic [15:0] COMPARE_VALUE = wake_pkg::COMPARE_1S,
  parameter logic [7:0] EXTENSION = wake_pkg::EXTENSION_DEFAULT,
  parameter int PRESCALE = wake_pkg::PRESCALE_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic low_freq_crystal_clock,
  wake_link_if.device link,
  output logic deep_sleep_state,
  output logic count_busy,
  output logic compare_hit,
  output logic [wake_pkg::IGN_W-1:0] ignored_starts
);
  import wake_pkg::*;

  localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(WAKE_PULSE_CYCLES - 1);

  // ignored starts wrap instead of saturating; the count is a debug aid, never a limit
  function automatic logic [IGN_W-1:0] next_ignored(input logic [IGN_W-1:0] cnt);
    next_ignored = cnt + IGN_W'(1);
  endfunction : next_ignored

  // asleep means nothing but the start detector is live
  function automatic logic is_idle(input dev_state_t st);
    is_idle = (st == DEV_IDLE);
  endfunction : is_idle

  // a compare period ends on the tick that brings the counter up to the compare value
  function automatic logic period_done(input logic [COMPARE_W-1:0] next_cnt, input logic [COMPARE_W-1:0] cmp);
    period_done = (next_cnt == cmp);
  endfunction : period_done

  // all state of the device end except the prescaler's, which sits in u_presc
  typedef struct packed {
    dev_state_t state;
    logic start_prev;
    logic [COMPARE_W-1:0] wake_compare_value;
    logic [COMPARE_W-1:0] tick_cnt;
    logic [EXT_W-1:0] ext_cnt;
    logic [PULSE_W-1:0] pulse_cnt;
    logic wake;
    logic sleep;
    logic busy;
    logic hit;
    logic [IGN_W-1:0] ignored;
  } dev_t;

  dev_t s_q;
  dev_t s_d;
  logic tick;
  logic start_rose;
  logic [COMPARE_W-1:0] tick_next;

  // the prescaler only runs while counting, so every interval
  // starts on a fresh prescale boundary; the price is up to one
  // crystal edge of jitter on the first tick after the start
  // limitation: the crystal must toggle slower than half of pclk
  // crystal divide by 1024
  wake_prescaler #(
    .DIV(PRESCALE)
  ) u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .clear(s_q.state != DEV_COUNT),
    .xtal(low_freq_crystal_clock),
    .tick(tick)
  );

  // start line is sampled every cycle; a rise is seen once and then forgotten
  // detect start edge
  assign start_rose = rose(s_q.start_prev, link.start_req);

  // 16-bit wrap lets a compare value of zero mean a full 65536-tick period
  // and keeps the adder the same width as the compare register
  assign tick_next = s_q.tick_cnt + COMPARE_W'(1);

  // interval sequencer
  // idle: waiting for a start rise, prescaler held clear
  // count: ticks run up to the compare value, then the extension count
  //   decides whether another compare period follows
  // pulse: wake line held high for a fixed width; starts still refused
  always_comb
  begin
    s_d = s_q;
    s_d.start_prev = link.start_req;
    s_d.hit = 1'b0;
    case (s_q.state)
      DEV_IDLE:
      begin
        // counters restart from zero so every interval has its full length
        // edge starts the count
        if (start_rose)
        begin
          s_d.state = DEV_COUNT;
          s_d.tick_cnt = '0;
          s_d.ext_cnt = '0;
        end
      end
      DEV_COUNT:
      begin
        // a refused start is counted and otherwise forgotten
        // edges during count dropped
        if (start_rose)
        begin
          s_d.ignored = next_ignored(s_q.ignored);
        end
        // one step per prescaler tick
        if (tick)
        begin
          if (period_done(tick_next, s_q.wake_compare_value))
          begin
            s_d.hit = 1'b1;
            s_d.tick_cnt = '0;
            if (s_q.ext_cnt == EXTENSION)
            begin
              s_d.state = DEV_PULSE;
              s_d.wake = 1'b1;
              s_d.pulse_cnt = '0;
            end
            else
            begin
              s_d.ext_cnt = s_q.ext_cnt + EXT_W'(1);
            end
          end
          else
          begin
            s_d.tick_cnt = tick_next;
          end
        end
      end
      DEV_PULSE:
      begin
        if (start_rose)
        begin
          s_d.ignored = next_ignored(s_q.ignored);
        end
        if (s_q.pulse_cnt == PULSE_LAST)
        begin
          s_d.wake = 1'b0;
          s_d.state = DEV_IDLE;
        end
        else
        begin
          s_d.pulse_cnt = s_q.pulse_cnt + PULSE_W'(1);
        end
      end
      // unused state code: fall back to idle with the wake line low
      default:
      begin
        s_d.state = DEV_IDLE;
        s_d.wake = 1'b0;
      end
    endcase
    s_d.sleep = is_idle(s_d.state);
    s_d.busy = !is_idle(s_d.state);
    s_d.wake_compare_value = s_q.wake_compare_value;
  end

  // compare value loads its build-time setting at reset and is held
  // sleep resets high so the device comes up in its idle state
  // build-time compare setting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.state <= DEV_IDLE;
      s_q.sleep <= 1'b1;
      s_q.wake_compare_value <= COMPARE_VALUE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  // wake is a level pulse, so the host must look for its rising edge
  // only two link lines
  assign link.wake_note = s_q.wake;
  assign deep_sleep_state = s_q.sleep;
  assign count_busy = s_q.busy;
  assign compare_hit = s_q.hit;
  assign ignored_starts = s_q.ignored;

endmodule : wake_timer_dev

// [hw/wake_pkg.sv]
// constants, types and helpers shared by both ends of the wake-up timer link
package wake_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 10;

  // low-frequency crystal and prescaler: 32768 / 1024 gives 32 ticks a second
  localparam int XTAL_HZ = 32768;
  localparam int PRESCALE_DIV = 1024;
  localparam int PRESC_W = 10;
  localparam int TICKS_PER_SECOND = XTAL_HZ / PRESCALE_DIV;

  // compare value and extension, fixed at build time
  localparam int COMPARE_W = 16;
  localparam logic [15:0] COMPARE_1S = 16'h0020;
  localparam logic [15:0] COMPARE_30MIN = 16'hE0FF;
  localparam int EXT_W = 8;
  localparam logic [7:0] EXTENSION_DEFAULT = 8'h01;

  // wake pulse width on the link
  localparam int PULSE_W = 4;
  localparam int WAKE_PULSE_NS = 40;
  localparam int WAKE_PULSE_CYCLES_RAW = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_PULSE_CYCLES = (WAKE_PULSE_CYCLES_RAW < 1) ? 1 : WAKE_PULSE_CYCLES_RAW;

  // start request high time driven by the host
  localparam int START_HOLD_NS = 40;
  localparam int START_HOLD_CYCLES_RAW = (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_HOLD_CYCLES = (START_HOLD_CYCLES_RAW < 1) ? 1 : START_HOLD_CYCLES_RAW;

  // host register map over APB
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] WAKES_OFFSET = 12'h008;
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_WAIT_BIT = 0;
  localparam int STAT_WOKE_BIT = 1;
  localparam int WAKES_W = 16;
  localparam int IGN_W = 8;

  typedef enum logic [1:0] {DEV_IDLE, DEV_COUNT, DEV_PULSE} dev_state_t;
  typedef enum logic [1:0] {HOST_IDLE, HOST_START, HOST_SLEEP} host_state_t;

  // low-to-high transition between two samples
  function automatic logic rose(input logic prev, input logic now);
    rose = now & ~prev;
  endfunction : rose

endpackage : wake_pkg

// [hw/wake_link_if.sv]
// two-line link between the host controller and the wake-up timer
`timescale 1ns/1ps
interface wake_link_if;
  logic start_req;
  logic wake_note;

  modport device
  (
    input start_req,
    output wake_note
  );

  modport host
  (
    output start_req,
    input wake_note
  );
endinterface : wake_link_if

// [hw/wake_prescaler.sv]
// divides sampled crystal edges down to one tick per prescale period
`timescale 1ns/1ps
module wake_prescaler #(
  parameter int DIV = wake_pkg::PRESCALE_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic xtal,
  output logic tick
);
  import wake_pkg::*;

  typedef struct packed {
    logic xtal_prev;
    logic [PRESC_W-1:0] cnt;
    logic tick;
  } presc_t;

  localparam logic [PRESC_W-1:0] LAST = PRESC_W'(DIV - 1);

  presc_t s_q;
  presc_t s_d;

  // count rising crystal edges; clear keeps the phase aligned to the start edge
  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.xtal_prev = xtal;
    if (clear)
    begin
      s_d.cnt = '0;
    end
    else if (rose(s_q.xtal_prev, xtal))
    begin
      if (s_q.cnt == LAST)
      begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt + PRESC_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : wake_prescaler

// [hw/wake_host_ctrl.sv]
// host end: APB-controlled start request and wake reception
`timescale 1ns/1ps
module wake_host_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wake_pkg::ADDR_W-1:0] paddr,
  input wire logic [wake_pkg::DATA_W-1:0] pwdata,
  output logic [wake_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  wake_link_if.host link,
  output logic host_asleep
);
  import wake_pkg::*;

  localparam logic [PULSE_W-1:0] HOLD_LAST = PULSE_W'(START_HOLD_CYCLES - 1);

  typedef struct packed {
    host_state_t state;
    logic start;
    logic [PULSE_W-1:0] hold_cnt;
    logic wake_prev;
    logic woke;
    logic [WAKES_W-1:0] wakes;
    logic asleep;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } host_t;

  host_t s_q;
  host_t s_d;
  logic access;
  logic do_write;
  logic wake_rose;

  assign access = psel & penable;
  // a write lands only at the edge where pready is sampled high
  assign do_write = access & s_q.pready & pwrite & ~s_q.pslverr;
  assign wake_rose = rose(s_q.wake_prev, link.wake_note);

  always_comb
  begin
    s_d = s_q;
    s_d.wake_prev = link.wake_note;
    // apb: one wait cycle, answer registered, then release
    if (access && !s_q.pready)
    begin
      s_d.pready = 1'b1;
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
      if (paddr == CTRL_OFFSET)
      begin
        s_d.prdata[CTRL_START_BIT] = s_q.start;
      end
      else if (paddr == STATUS_OFFSET)
      begin
        s_d.prdata[STAT_WAIT_BIT] = (s_q.state != HOST_IDLE);
        s_d.prdata[STAT_WOKE_BIT] = s_q.woke;
      end
      else if (paddr == WAKES_OFFSET)
      begin
        s_d.prdata[WAKES_W-1:0] = s_q.wakes;
      end
      else
      begin
        s_d.pslverr = 1'b1;
      end
    end
    else if (access && s_q.pready)
    begin
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
    end
    // write-one clears the woke flag; a wake in the same cycle sets it again below
    if (do_write && paddr == STATUS_OFFSET && pwdata[STAT_WOKE_BIT])
    begin
      s_d.woke = 1'b0;
    end
    case (s_q.state)
      HOST_IDLE:
      begin
        // each interval needs a new rise
        if (do_write && paddr == CTRL_OFFSET && pwdata[CTRL_START_BIT])
        begin
          s_d.state = HOST_START;
          s_d.start = 1'b1;
          s_d.hold_cnt = '0;
        end
      end
      HOST_START:
      begin
        if (s_q.hold_cnt == HOLD_LAST)
        begin
          s_d.start = 1'b0;
          s_d.state = HOST_SLEEP;
          s_d.asleep = 1'b1;
        end
        else
        begin
          s_d.hold_cnt = s_q.hold_cnt + PULSE_W'(1);
        end
      end
      HOST_SLEEP:
      begin
        if (wake_rose)
        begin
          s_d.woke = 1'b1;
          s_d.wakes = s_q.wakes + WAKES_W'(1);
          s_d.asleep = 1'b0;
          s_d.state = HOST_IDLE;
        end
      end
      default:
      begin
        s_d.state = HOST_IDLE;
        s_d.start = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.state <= HOST_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign link.start_req = s_q.start;
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign host_asleep = s_q.asleep;

endmodule : wake_host_ctrl

// [verification/wake_link_checker.sv]
// concurrent checks on the wake link between host and device
`timescale 1ns/1ps
module wake_link_checker #(
  parameter logic [7:0] EXTENSION = 8'h01
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start_req,
  input wire logic wake_note,
  input wire logic deep_sleep_state,
  input wire logic count_busy,
  input wire logic compare_hit,
  input wire logic host_asleep
);
  logic [7:0] hits_q;
  logic [7:0] hits_d;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // matches seen in the running interval, cleared once idle
  always_comb hits_d = count_busy ? hits_q + {7'h00, compare_hit} : 8'h00;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hits_q <= 8'h00;
    else
      hits_q <= hits_d;

  wake_pulse_a: assert property (
    $rose(wake_note) |-> wake_note[*4] ##1 !wake_note) else $error("wake pulse width");
  start_arm_a: assert property (
    $rose(start_req) && deep_sleep_state |-> ##[1:2] count_busy) else $error("start not taken");
  idle_quiet_a: assert property (
    deep_sleep_state |-> !count_busy && !wake_note && !compare_hit) else $error("busy while idle");
  // the wake match must come after EXTENSION earlier matches
  ext_count_a: assert property (
    $rose(wake_note) |-> compare_hit && hits_q == EXTENSION) else $error("wrong match count");
  pulse_end_a: assert property (
    $fell(wake_note) |-> !count_busy && deep_sleep_state) else $error("not idle after wake");
  start_hold_a: assert property (
    $rose(start_req) |-> start_req[*4] ##1 !start_req) else $error("start width");
  host_sleep_a: assert property (
    $fell(start_req) |-> host_asleep) else $error("host not asleep");
  host_wake_a: assert property (
    $rose(wake_note) && host_asleep |=> !host_asleep) else $error("host not woken");

  cover property ($rose(wake_note));
  cover property ($fell(host_asleep));
  cover property ($rose(start_req) && deep_sleep_state);
endmodule : wake_link_checker

// [verification/tb.sv]
// self-checking bench: host and device joined over the wake link
`timescale 1ns/1ps
module tb;
  import wake_pkg::*;
  localparam logic [15:0] CMP = 16'h0003;
  localparam logic [7:0] EXT = 8'h01;
  localparam int PS = 4;
  localparam int N1 = (EXT + 1) * CMP * PS;
  localparam int N2 = 5 * PS;
  logic pclk = 0;
  logic presetn = 0;
  logic xtal = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, host_asleep, deep_sleep_state, count_busy, compare_hit, busy2, sleep2;
  logic [7:0] ign1, ign2;
  logic [32:0] exp_q[$];
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int xcnt = 0;
  int d;
  integer seed = 72;
  wake_link_if link();
  wake_link_if link2();

  wake_host_ctrl u_wake_host_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link.host), .host_asleep(host_asleep));
  wake_timer_dev #(.COMPARE_VALUE(CMP), .EXTENSION(EXT), .PRESCALE(PS)) u_wake_timer_dev (.pclk(pclk),
    .presetn(presetn), .low_freq_crystal_clock(xtal), .link(link.device), .deep_sleep_state(deep_sleep_state),
    .count_busy(count_busy), .compare_hit(compare_hit), .ignored_starts(ign1));
  // second device end, driven by the bench so host faults can be made
  wake_timer_dev #(.COMPARE_VALUE(16'h0005), .EXTENSION(8'h00), .PRESCALE(PS)) u_wake_timer_dev_2 (.pclk(pclk),
    .presetn(presetn), .low_freq_crystal_clock(xtal), .link(link2.device), .deep_sleep_state(sleep2),
    .count_busy(busy2), .compare_hit(), .ignored_starts(ign2));
  wake_link_checker #(.EXTENSION(EXT)) u_wake_link_checker (.pclk(pclk), .presetn(presetn),
    .start_req(link.start_req), .wake_note(link.wake_note), .deep_sleep_state(deep_sleep_state),
    .count_busy(count_busy), .compare_hit(compare_hit), .host_asleep(host_asleep));

  initial forever #5 pclk = ~pclk;

  // crystal at random spacing, always well below half the bus clock
  initial forever
  begin
    repeat (2 + {$random(seed)} % 3) @(posedge pclk);
    xtal <= ~xtal;
  end
  always @(posedge xtal) xcnt++;

  // a hang is cut short well past the expected run length
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // one transfer; the expected {error, data} is noted first
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // k picks host start, host wake or second wake
  task automatic wait_for(input int k);
    logic [2:0] v;
    do
    begin
      @(posedge pclk);
      v = {link2.wake_note, link.wake_note, link.start_req};
    end
    while (v[k] !== 1'b1);
  endtask : wait_for

  // finished transfers are matched against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
      chk("apb", {pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());

  initial
  begin
    link2.start_req <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk("reset", {link.start_req, link.wake_note, deep_sleep_state, count_busy, host_asleep}, 5'b00100);
    apb(1'b0, 12'h00C, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h00C, 32'h1, {1'b1, 32'h0});
    // two intervals, each needing its own start
    for (int i = 1; i <= 2; i++)
    begin
      apb(1'b1, CTRL_OFFSET, 32'h1, 33'h0);
      wait_for(0);
      d = xcnt;
      apb(1'b0, CTRL_OFFSET, 32'h0, 33'h1);
      apb(1'b0, STATUS_OFFSET, 32'h0, 33'h1);
      apb(1'b1, CTRL_OFFSET, 32'h1, 33'h0);
      wait_for(1);
      d = xcnt - d;
      chk("edges", d >= N1 - 1 && d <= N1 + 1, 1'b1);
      apb(1'b0, STATUS_OFFSET, 32'h0, 33'h2);
      apb(1'b0, WAKES_OFFSET, 32'h0, 33'(i));
      apb(1'b1, STATUS_OFFSET, 32'h2, 33'h0);
    end
    // restarts attempted during a count must change nothing but the ignored-start count
    link2.start_req <= 1'b1;
    @(posedge pclk);
    d = xcnt;
    repeat (2)
    begin
      repeat (8) @(posedge pclk);
      link2.start_req <= 1'b0;
      repeat (8) @(posedge pclk);
      link2.start_req <= 1'b1;
    end
    wait_for(2);
    d = xcnt - d;
    chk("edges2", d >= N2 - 1 && d <= N2 + 1, 1'b1);
    chk("ignored", ign2, 33'h2);
    // a line left high gives no second interval
    repeat (200) @(posedge pclk);
    chk("held", {busy2, sleep2}, 2'b01);
    link2.start_req <= 1'b0;
    @(posedge pclk);
    link2.start_req <= 1'b1;
    wait_for(2);
    chk("fresh", ign2, 33'h2);
    chk("ign1", ign1, 33'h0);
    final_report();
  end
endmodule : tb
